//--- logic/fwsr_map.svh
`ifndef FWSR_MAP_SVH
`define FWSR_MAP_SVH

// Clock period of the controller
`define FWSR_CLK_NS 25
// Read strobe length, least time, rounded up
`define FWSR_T_READ_NS 100
`define FWSR_READ_CYC ((`FWSR_T_READ_NS + `FWSR_CLK_NS - 1) / `FWSR_CLK_NS)
// Write strobe length, least time, rounded up
`define FWSR_T_WRITE_NS 35
`define FWSR_WRITE_CYC ((`FWSR_T_WRITE_NS + `FWSR_CLK_NS - 1) / `FWSR_CLK_NS)

// Status bit positions on the data bus
`define FWSR_BIT_COMPLEMENT_POLL 7
`define FWSR_BIT_TOGGLE_STATUS 6
`define FWSR_BIT_TIMEOUT_ERROR 5
`define FWSR_BIT_ERASE_TIMER 3
`define FWSR_BIT_ERASE_SECTOR_TOGGLE 2

// Reset command data, written to any address
`define FWSR_RESET_DATA 8'hf0
`define FWSR_RESET_ADDR 0

// Default bound on status reads in one poll
`define FWSR_POLL_MAX_DEF 1000000

`endif

//--- logic/fwsr_pkg.sv
package fwsr_pkg;

	typedef enum logic [1:0] {
		FWSR_OP_POLL = 2'h0,
		FWSR_OP_RESET = 2'h1,
		FWSR_OP_WRITE = 2'h2,
		FWSR_OP_ERASE_ADD = 2'h3
	} fwsr_op_e;

	typedef enum logic [2:0] {
		FWSR_RSP_OK = 3'h0,
		FWSR_RSP_FAIL = 3'h1,
		FWSR_RSP_REJECTED = 3'h2,
		FWSR_RSP_ABORTED = 3'h3,
		FWSR_RSP_LIMIT = 3'h4
	} fwsr_rsp_e;

	typedef enum logic [3:0] {
		FWSR_ST_IDLE = 4'h0,
		FWSR_ST_READ1 = 4'h1,
		FWSR_ST_READN = 4'h3,
		FWSR_ST_PRE = 4'h2,
		FWSR_ST_WRITE = 4'h6,
		FWSR_ST_POST = 4'h7,
		FWSR_ST_RESET = 4'h5,
		FWSR_ST_DONE = 4'h4
	} fwsr_state_e;

endpackage

//--- logic/fwsr_cyc_if.sv
`timescale 1ns/1ps
interface fwsr_cyc_if #(
	parameter int ADDR_W = 22,
	parameter int DATA_W = 16
);
	logic req;
	logic we;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;
	logic done;

	modport master (output req, output we, output addr, output wdata, input rdata, input done);
	modport slave (input req, input we, input addr, input wdata, output rdata, output done);
endinterface

//--- logic/fwsr_bus_cycle.sv
`timescale 1ns/1ps
`include "fwsr_map.svh"
module fwsr_bus_cycle import fwsr_pkg::*; #(
	parameter int ADDR_W = 22,
	parameter int DATA_W = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Cycle requests
	fwsr_cyc_if.slave cyc,
	// Flash pins
	output logic [ADDR_W-1:0] flash_addr,
	output logic flash_ce_n,
	output logic flash_oe_n,
	output logic flash_we_n,
	output logic [DATA_W-1:0] flash_dq_o,
	output logic flash_dq_oe,
	input wire logic [DATA_W-1:0] flash_dq_i
);

	localparam logic [3:0] READ_CYC = 4'(`FWSR_READ_CYC);
	localparam logic [3:0] WRITE_CYC = 4'(`FWSR_WRITE_CYC);

	logic active_q;
	logic [3:0] cnt_q;
	logic done_q;
	logic [DATA_W-1:0] rdata_q;

	assign cyc.done = done_q;
	assign cyc.rdata = rdata_q;

	////////////////////////////////////////////////////////////////////////
	// Each read is its own chip-select and output-strobe frame, so both
	// toggle bits advance whichever strobe the device counts.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			active_q <= 1'b0;
			cnt_q <= 4'h0;
			done_q <= 1'b0;
			rdata_q <= '0;
			flash_addr <= '0;
			flash_ce_n <= 1'b1;
			flash_oe_n <= 1'b1;
			flash_we_n <= 1'b1;
			flash_dq_o <= '0;
			flash_dq_oe <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (!active_q) begin
				// Data released one cycle after the write edge for hold
				flash_dq_oe <= 1'b0;
				if (cyc.req) begin
					active_q <= 1'b1;
					flash_addr <= cyc.addr;
					flash_dq_o <= cyc.wdata;
					flash_dq_oe <= cyc.we;
					flash_ce_n <= 1'b0;
					flash_we_n <= !cyc.we;
					flash_oe_n <= cyc.we;
					cnt_q <= cyc.we ? WRITE_CYC : READ_CYC;
				end
			end else if (cnt_q > 4'h1) begin
				cnt_q <= cnt_q - 4'h1;
			end else begin
				// Write strobe rises here, which starts the device's status
				if (!flash_oe_n) begin
					rdata_q <= flash_dq_i;
				end
				active_q <= 1'b0;
				flash_ce_n <= 1'b1;
				flash_oe_n <= 1'b1;
				flash_we_n <= 1'b1;
				done_q <= 1'b1;
				cnt_q <= 4'h0;
			end
		end
	end

endmodule

//--- logic/fwsr_host.sv
// Summary of operation
// - Poll starts with two reads, compare
// - Timeout plus toggling: recheck, then reset
// - Resumed polling restarts with double read
// - After timeout write reset command
// - Short erase spacing may skip timer; here the timer is always checked
// - Check erase timer before and after
`timescale 1ns/1ps
`include "fwsr_map.svh"
module fwsr_host import fwsr_pkg::*; #(
	parameter int ADDR_W = 22,
	parameter int DATA_W = 16,
	parameter int POLL_MAX = `FWSR_POLL_MAX_DEF
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// User commands
	input wire logic cmd_valid,
	input wire logic [1:0] cmd_op,
	input wire logic [ADDR_W-1:0] cmd_addr,
	input wire logic [DATA_W-1:0] cmd_data,
	input wire logic poll_abort,
	output logic cmd_ready,
	// User answers
	output logic rsp_valid,
	output logic [2:0] rsp_code,
	output logic [DATA_W-1:0] rsp_data,
	output logic stat_toggling,
	output logic stat_sector_toggling,
	output logic stat_timeout,
	output logic stat_erase_started,
	output logic stat_busy,
	// Flash pins
	output logic [ADDR_W-1:0] flash_addr,
	output logic flash_ce_n,
	output logic flash_oe_n,
	output logic flash_we_n,
	output logic [DATA_W-1:0] flash_dq_o,
	output logic flash_dq_oe,
	input wire logic [DATA_W-1:0] flash_dq_i,
	input wire logic busy_indicator
);

	// Bit 7 is the highest status bit read, so narrower buses cannot serve
	if (DATA_W < 8 || ADDR_W < 1 || POLL_MAX < 2 || POLL_MAX > 32'h7fffffff) begin : g_bad_param
		$error("fwsr_host: unsupported parameter values");
	end

	fwsr_cyc_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) cyc ();

	fwsr_bus_cycle #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_cycle (
		.clk(clk),
		.reset_n(reset_n),
		.cyc(cyc.slave),
		.flash_addr(flash_addr),
		.flash_ce_n(flash_ce_n),
		.flash_oe_n(flash_oe_n),
		.flash_we_n(flash_we_n),
		.flash_dq_o(flash_dq_o),
		.flash_dq_oe(flash_dq_oe),
		.flash_dq_i(flash_dq_i)
	);

	function automatic logic bit_moved(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b, input int pos);
		bit_moved = a[pos] ^ b[pos];
	endfunction

	fwsr_state_e state_q;
	fwsr_op_e op_q;
	logic req_q;
	logic we_q;
	logic [ADDR_W-1:0] addr_q;
	logic [DATA_W-1:0] wdata_q;
	logic [DATA_W-1:0] prev_q;
	logic recheck_q;
	logic [31:0] reads_q;
	logic [2:0] code_q;

	assign cyc.req = req_q;
	assign cyc.we = we_q;
	assign cyc.addr = addr_q;
	assign cyc.wdata = wdata_q;

	logic moved;
	logic sector_moved;
	assign moved = bit_moved(prev_q, cyc.rdata, `FWSR_BIT_TOGGLE_STATUS);
	assign sector_moved = bit_moved(prev_q, cyc.rdata, `FWSR_BIT_ERASE_SECTOR_TOGGLE);

	////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_q <= FWSR_ST_IDLE;
			op_q <= FWSR_OP_POLL;
			req_q <= 1'b0;
			we_q <= 1'b0;
			addr_q <= '0;
			wdata_q <= '0;
			prev_q <= '0;
			recheck_q <= 1'b0;
			reads_q <= 32'h0;
			code_q <= FWSR_RSP_OK;
		end else begin
			req_q <= 1'b0;
			case (state_q)
				FWSR_ST_IDLE: begin
					if (cmd_valid) begin
						op_q <= fwsr_op_e'(cmd_op);
						addr_q <= cmd_addr;
						wdata_q <= cmd_data;
						recheck_q <= 1'b0;
						reads_q <= 32'h1;
						req_q <= 1'b1;
						we_q <= 1'b0;
						case (fwsr_op_e'(cmd_op))
							// Every poll opens with a fresh double read
							FWSR_OP_POLL: state_q <= FWSR_ST_READ1;
							FWSR_OP_RESET: begin
								addr_q <= ADDR_W'(`FWSR_RESET_ADDR);
								wdata_q <= DATA_W'(`FWSR_RESET_DATA);
								we_q <= 1'b1;
								state_q <= FWSR_ST_WRITE;
							end
							FWSR_OP_WRITE: begin
								we_q <= 1'b1;
								state_q <= FWSR_ST_WRITE;
							end
							// Timer always checked, no spacing shortcut
							// Timer checked before the added erase command
							FWSR_OP_ERASE_ADD: state_q <= FWSR_ST_PRE;
							default: state_q <= FWSR_ST_IDLE;
						endcase
					end
				end
				FWSR_ST_READ1: begin
					if (cyc.done) begin
						prev_q <= cyc.rdata;
						reads_q <= reads_q + 32'h1;
						req_q <= 1'b1;
						state_q <= FWSR_ST_READN;
					end
				end
				FWSR_ST_READN: begin
					if (cyc.done) begin
						prev_q <= cyc.rdata;
						reads_q <= reads_q + 32'h1;
						if (!moved) begin
							code_q <= FWSR_RSP_OK;
							state_q <= FWSR_ST_DONE;
						end else if (recheck_q) begin
							// Still toggling after timeout: fail and send reset
							code_q <= FWSR_RSP_FAIL;
							addr_q <= ADDR_W'(`FWSR_RESET_ADDR);
							wdata_q <= DATA_W'(`FWSR_RESET_DATA);
							we_q <= 1'b1;
							req_q <= 1'b1;
							state_q <= FWSR_ST_RESET;
						end else if (poll_abort) begin
							// Next poll starts from scratch
							code_q <= FWSR_RSP_ABORTED;
							state_q <= FWSR_ST_DONE;
						end else if (reads_q >= 32'(POLL_MAX)) begin
							code_q <= FWSR_RSP_LIMIT;
							state_q <= FWSR_ST_DONE;
						end else begin
							// Toggle may stop as the timeout bit rises, so read once more
							recheck_q <= cyc.rdata[`FWSR_BIT_TIMEOUT_ERROR];
							req_q <= 1'b1;
						end
					end
				end
				FWSR_ST_PRE: begin
					if (cyc.done) begin
						if (cyc.rdata[`FWSR_BIT_ERASE_TIMER]) begin
							// Erase already started; command would be ignored
							code_q <= FWSR_RSP_REJECTED;
							state_q <= FWSR_ST_DONE;
						end else begin
							we_q <= 1'b1;
							req_q <= 1'b1;
							state_q <= FWSR_ST_WRITE;
						end
					end
				end
				FWSR_ST_WRITE: begin
					if (cyc.done) begin
						code_q <= FWSR_RSP_OK;
						we_q <= 1'b0;
						if (op_q == FWSR_OP_ERASE_ADD) begin
							req_q <= 1'b1;
							state_q <= FWSR_ST_POST;
						end else begin
							state_q <= FWSR_ST_DONE;
						end
					end
				end
				FWSR_ST_POST: begin
					if (cyc.done) begin
						// Timer high on second check: last command may be lost
						code_q <= cyc.rdata[`FWSR_BIT_ERASE_TIMER] ? FWSR_RSP_REJECTED : FWSR_RSP_OK;
						state_q <= FWSR_ST_DONE;
					end
				end
				FWSR_ST_RESET: begin
					if (cyc.done) begin
						we_q <= 1'b0;
						state_q <= FWSR_ST_DONE;
					end
				end
				FWSR_ST_DONE: state_q <= FWSR_ST_IDLE;
				default: state_q <= FWSR_ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Answers to the user
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cmd_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_code <= FWSR_RSP_OK;
			rsp_data <= '0;
		end else begin
			cmd_ready <= (state_q == FWSR_ST_DONE) || (state_q == FWSR_ST_IDLE && !cmd_valid);
			rsp_valid <= (state_q == FWSR_ST_DONE);
			if (state_q == FWSR_ST_DONE) begin
				rsp_code <= code_q;
				rsp_data <= prev_q;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status view, refreshed on each status read
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			stat_toggling <= 1'b0;
			stat_sector_toggling <= 1'b0;
			stat_timeout <= 1'b0;
			stat_erase_started <= 1'b0;
		end else if (cyc.done && !we_q) begin
			// Toggle bits compare only within one poll; first read has no partner
			if (state_q == FWSR_ST_READN) begin
				stat_toggling <= moved;
				stat_sector_toggling <= sector_moved;
			end
			stat_timeout <= cyc.rdata[`FWSR_BIT_TIMEOUT_ERROR];
			stat_erase_started <= cyc.rdata[`FWSR_BIT_ERASE_TIMER];
		end
	end

	// Shared busy line is only observed; the pull-up lives on the board
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			stat_busy <= 1'b0;
		end else begin
			stat_busy <= !busy_indicator;
		end
	end

endmodule

//--- test/fwsr_host_checker.sv
`timescale 1ns/1ps
module fwsr_host_checker import fwsr_pkg::*; #(
	parameter int ADDR_W = 22,
	parameter int DATA_W = 16,
	parameter int POLL_MAX = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// User answers
	input wire logic rsp_valid,
	input wire logic [2:0] rsp_code,
	input wire logic stat_toggling,
	input wire logic stat_timeout,
	input wire logic stat_busy,
	// Flash pins
	input wire logic [ADDR_W-1:0] flash_addr,
	input wire logic flash_ce_n,
	input wire logic flash_oe_n,
	input wire logic flash_we_n,
	input wire logic [DATA_W-1:0] flash_dq_o,
	input wire logic flash_dq_oe,
	input wire logic busy_indicator
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic [DATA_W-1:0] wd_q;
	logic [ADDR_W-1:0] wa_q;
	////////////////////////////////////////////////////////////////
	// Last written word, so a failure answer can be tied to recovery
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wd_q <= '0;
			wa_q <= '0;
		end else if (!flash_we_n) begin
			wd_q <= flash_dq_o;
			wa_q <= flash_addr;
		end
	end
	////////////////////////////////////////////////////////////////
	a_read_four: assert property ($fell(flash_oe_n) |-> !flash_oe_n [*4] ##1 flash_oe_n)
		else $error("read strobe not four cycles");
	a_read_framed: assert property (!flash_oe_n |-> !flash_ce_n && flash_we_n && !flash_dq_oe)
		else $error("read frame malformed");
	a_write_two: assert property ($fell(flash_we_n) |-> !flash_we_n [*2] ##1 flash_we_n)
		else $error("write strobe not two cycles");
	a_write_drive: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe)
		else $error("write frame malformed");
	a_fail_recheck: assert property (rsp_valid && rsp_code == FWSR_RSP_FAIL |-> stat_toggling && stat_timeout)
		else $error("failure without toggling and timeout");
	a_fail_reset: assert property (rsp_valid && rsp_code == FWSR_RSP_FAIL |-> wd_q[7:0] == 8'hf0 && wa_q == '0)
		else $error("failure answered before reset write");
	a_busy_seen: assert property (!busy_indicator [*2] |-> stat_busy)
		else $error("busy line low but not reported");
	a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
		else $error("answer pulse longer than one cycle");
	c_fail: cover property (rsp_valid && rsp_code == FWSR_RSP_FAIL);
	c_abort: cover property (rsp_valid && rsp_code == FWSR_RSP_ABORTED);
	c_limit: cover property (rsp_valid && rsp_code == FWSR_RSP_LIMIT);
	c_reject: cover property (rsp_valid && rsp_code == FWSR_RSP_REJECTED);
endmodule

bind fwsr_host fwsr_host_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .POLL_MAX(POLL_MAX)) u_chk (.clk, .reset_n,
	.rsp_valid, .rsp_code, .stat_toggling, .stat_timeout, .stat_busy, .flash_addr, .flash_ce_n, .flash_oe_n,
	.flash_we_n, .flash_dq_o, .flash_dq_oe, .busy_indicator);

//--- test/fwsr_flash_model.sv
`timescale 1ns/1ps
module fwsr_flash_model #(
	parameter int ADDR_W = 22,
	parameter int DATA_W = 16
) (
	// Flash pins
	input wire logic [ADDR_W-1:0] flash_addr,
	input wire logic flash_ce_n,
	input wire logic flash_oe_n,
	input wire logic flash_we_n,
	input wire logic [DATA_W-1:0] flash_dq_o,
	output logic [DATA_W-1:0] flash_dq_i,
	output logic busy_indicator,
	// Scenario knobs
	input int busy_len,
	input wire logic err_mode,
	input wire logic timer_on
);
	int left_q = 0;
	logic err_q = 1'b0;
	logic tog_q = 1'b0;
	logic sec_q = 1'b0;
	logic [DATA_W-1:0] word;
	wire busy = (left_q > 0) || err_q;
	wire rd_n = flash_ce_n | flash_oe_n;
	wire wr_n = flash_ce_n | flash_we_n;
	////////////////////////////////////////////////////////////////
	always_comb begin
		word = '0;
		word[7] = !busy;
		word[6] = tog_q;
		word[5] = err_q;
		word[3] = timer_on;
		word[2] = sec_q;
	end
	// Released bus shows the inverse, never a stale copy
	assign flash_dq_i = rd_n ? ~word : word;
	// Pull-up wins whenever nobody pulls low
	assign busy_indicator = busy ? 1'b0 : 1'b1;
	////////////////////////////////////////////////////////////////
	// Either strobe ends a read; both toggles move together
	always @(posedge rd_n) begin
		if (flash_we_n && busy) begin
			tog_q <= !tog_q;
			sec_q <= !sec_q;
			if (left_q > 0) left_q <= left_q - 1;
		end
	end
	// Busy from the last write edge; error holds until reset data or a write with err_mode low
	always @(posedge wr_n) begin
		if (flash_dq_o[7:0] == 8'hf0) begin
			left_q <= 0;
			err_q <= 1'b0;
		end else begin
			// Protected targets modelled only as a short toggle span
			left_q <= busy_len;
			err_q <= err_mode;
		end
	end
endmodule

//--- test/fwsr_host_bench.sv
`timescale 1ns/1ps
module fwsr_host_bench import fwsr_pkg::*; ;
	logic clk, reset_n, cmd_valid, poll_abort, cmd_ready, rsp_valid, stat_toggling, stat_sector_toggling;
	logic stat_timeout, stat_erase_started, stat_busy, flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe;
	logic busy_indicator, err_mode, timer_on, oe_d;
	logic [1:0] cmd_op;
	logic [2:0] rsp_code;
	logic [21:0] cmd_addr, flash_addr;
	logic [15:0] cmd_data, rsp_data, flash_dq_o, flash_dq_i;
	int busy_len, rd_cnt, nrsp, failures, samples_checked;
	int seed = 32'h75b80e12;
	logic [2:0] code_q[$];
	int rd_q[$];
	fwsr_host #(.POLL_MAX(8)) i_dut (.clk, .reset_n, .cmd_valid, .cmd_op, .cmd_addr, .cmd_data, .poll_abort,
		.cmd_ready, .rsp_valid, .rsp_code, .rsp_data, .stat_toggling, .stat_sector_toggling, .stat_timeout,
		.stat_erase_started, .stat_busy, .flash_addr, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_dq_o,
		.flash_dq_oe, .flash_dq_i, .busy_indicator);
	fwsr_flash_model i_flash (.flash_addr, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_dq_o, .flash_dq_i,
		.busy_indicator, .busy_len, .err_mode, .timer_on);
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("checked %0d, failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Not queued by the host, so wait for ready before each command
	task automatic run(input fwsr_op_e op, input logic [15:0] data, input logic [2:0] code, input int reads);
		int n;
		int old;
		n = 0;
		do begin
			@(posedge clk);
			#2;
			n++;
		end while (cmd_ready !== 1'b1 && n < 50);
		code_q.push_back(code);
		rd_q.push_back(reads);
		old = nrsp;
		rd_cnt = 0;
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_data = data;
		cmd_addr = 22'($random(seed));
		@(posedge clk);
		#2 cmd_valid = 1'b0;
		n = 0;
		while (nrsp == old && n < 500) begin
			@(posedge clk);
			n++;
		end
		if (nrsp == old) begin
			failures++;
			$display("unexpected at %0t: no answer", $time);
			test_done();
		end
	endtask
	////////////////////////////////////////////////////////////////
	always @(negedge clk) begin
		if (oe_d === 1'b1 && flash_oe_n === 1'b0) rd_cnt++;
		oe_d = flash_oe_n;
		if (reset_n === 1'b1 && rsp_valid === 1'b1) begin
			check(16'(rsp_code), 16'(code_q.pop_front()));
			if (rd_q[0] >= 0) check(16'(rd_cnt), 16'(rd_q[0]));
			void'(rd_q.pop_front());
			nrsp++;
		end
	end
	initial begin
		#500000;
		failures++;
		$display("unexpected at %0t: watchdog", $time);
		test_done();
	end
	initial begin
		{reset_n, cmd_valid, poll_abort, err_mode, timer_on, cmd_op, cmd_addr, cmd_data} = '0;
		{busy_len, rd_cnt, nrsp, failures, samples_checked} = '0;
		oe_d = 1'b1;
		repeat (8) @(posedge clk);
		#2 reset_n = 1'b1;
		run(FWSR_OP_RESET, 16'h0000, FWSR_RSP_OK, 0);
		for (int i = 0; i < 4; i++) begin
			busy_len = (i == 0) ? 0 : $unsigned($random(seed)) % 6;
			run(FWSR_OP_WRITE, 16'($random(seed)) | 16'h0001, FWSR_RSP_OK, 0);
			repeat (2) @(posedge clk);
			#2;
			check(16'(stat_busy), 16'(busy_len > 0));
			run(FWSR_OP_POLL, 16'h0000, FWSR_RSP_OK, busy_len + 2);
			#2;
			check(16'(stat_busy), 16'h0000);
			check(16'(stat_toggling), 16'h0000);
			check(16'(stat_sector_toggling), 16'h0000);
			check(rsp_data & 16'h00a8, 16'h0080);
			check(16'(flash_addr), 16'(cmd_addr));
		end
		$display("test poll done");
		err_mode = 1'b1;
		busy_len = 1;
		run(FWSR_OP_WRITE, 16'h0055, FWSR_RSP_OK, 0);
		run(FWSR_OP_POLL, 16'h0000, FWSR_RSP_FAIL, 3);
		check(16'(stat_timeout), 16'h0001);
		check(16'(stat_sector_toggling), 16'h0001);
		check(rsp_data & 16'h00a8, 16'h0020);
		check(16'(busy_indicator), 16'h0001);
		err_mode = 1'b0;
		$display("test failure done");
		busy_len = 20;
		run(FWSR_OP_WRITE, 16'h00a5, FWSR_RSP_OK, 0);
		#2 poll_abort = 1'b1;
		run(FWSR_OP_POLL, 16'h0000, FWSR_RSP_ABORTED, 2);
		#2 poll_abort = 1'b0;
		run(FWSR_OP_POLL, 16'h0000, FWSR_RSP_LIMIT, 8);
		run(FWSR_OP_RESET, 16'h0000, FWSR_RSP_OK, 0);
		run(FWSR_OP_POLL, 16'h0000, FWSR_RSP_OK, 2);
		$display("test abort done");
		busy_len = 0;
		run(FWSR_OP_ERASE_ADD, 16'h0030, FWSR_RSP_OK, 2);
		// Timer expires during the write, so only the second check sees it
		fork
			begin
				@(negedge flash_we_n);
				timer_on = 1'b1;
			end
		join_none
		run(FWSR_OP_ERASE_ADD, 16'h0030, FWSR_RSP_REJECTED, 2);
		run(FWSR_OP_ERASE_ADD, 16'h0030, FWSR_RSP_REJECTED, 1);
		#2;
		check(16'(stat_erase_started), 16'h0001);
		$display("test erase done");
		repeat (4) @(posedge clk);
		test_done();
	end
endmodule
